// File: hdl/swc_delay_timer.sv
// Purpose: Down counter timing the wake-up delay
// Assumes: load_i wins over counting
// Notes:   zero_o is true on the cycle after a load of zero
`timescale 1ns/1ps
module swc_delay_timer #(
  parameter int W = 12
) (
  input  wire logic         clk_i,    // System clock
  input  wire logic         reset_i,  // Sync reset
  input  wire logic         clk_en_i, // Freezes count when low
  input  wire logic         load_i,   // Load start value
  input  wire logic [W-1:0] value_i,  // Start value
  output logic              zero_o    // Count has run out
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = value_i;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_r <= '0;
    end else if (clk_en_i) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign zero_o = (cnt_r == '0);
endmodule // swc_delay_timer

// File: hdl/swc_pkg.sv
// Purpose: Shared constants for the sleep and wake controller
// Assumes: 40 MHz system clock, 32-bit AXI4-Lite register access
// Notes:   One oscillator period is taken as one system clock period
package swc_pkg;
  localparam int CLK_MHZ = 40;
  // Register byte offsets
  localparam logic [7:0] OFS_INTCTL = 8'h00;
  localparam logic [7:0] OFS_PERIPHERAL_ENABLE_SIX   = 8'h04;
  localparam logic [7:0] OFS_PERIPHERAL_REQUEST_FLAGS_SIX   = 8'h08;
  localparam logic [7:0] OFS_CFG    = 8'h0c;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  // Field positions
  localparam int INTCTL_GIE    = 7;
  localparam int INTCTL_EXT_IE = 4;
  localparam int FLAG_N        = 4;
  localparam int CFG_W         = 10;
  localparam int CFG_REGULATOR_POWER_MODE_SELECT    = 0;
  localparam int CFG_WDT_SLP   = 1;
  localparam int CFG_XTAL      = 2;
  localparam int CFG_TWOSPD    = 3;
  localparam int CFG_T1SRC     = 4;
  localparam int CFG_ADC_DED   = 6;
  localparam int CFG_PIN_EN    = 7;
  localparam int CFG_BOR_EN    = 8;
  localparam int CFG_WDT_EN    = 9;
  localparam int STAT_PD       = 0;
  localparam int STAT_TO       = 1;
  localparam int STAT_ASLEEP   = 2;
  // Reset values
  localparam logic [7:0]       RST_INTCTL = 8'h00;
  localparam logic [FLAG_N-1:0] RST_PERIPHERAL_ENABLE_SIX  = 4'h0;
  localparam logic [FLAG_N-1:0] RST_PERIPHERAL_REQUEST_FLAGS_SIX  = 4'h0;
  localparam logic [CFG_W-1:0] RST_CFG    = 10'h380;
  localparam logic             RST_PD     = 1'b1;
  localparam logic             RST_TO     = 1'b1;
  localparam logic [15:0]      ISR_VECTOR = 16'h0004;
  // Timing
  localparam int OST_TOSC     = 1024;
  localparam int OST_CYC      = OST_TOSC;
  localparam int REG_STAB_NS  = 2000;
  localparam int REG_STAB_CYC = (REG_STAB_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    SWC_RUN    = 5'h01,
    SWC_ENTRY  = 5'h02,
    SWC_SLEEP  = 5'h04,
    SWC_WAKE   = 5'h08,
    SWC_RESUME = 5'h10
  } swc_state_e;
endpackage

// File: hdl/swc_sleep_ctrl.sv
// Purpose: Sleep entry, wake-up and sixth peripheral flag register
// Assumes: sleep_exec_i is a one-cycle pulse from the core
// Notes:   Summary of operation follows
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module swc_sleep_ctrl #(
  parameter int ADDR_W = 8,
  parameter int DLY_W  = 12
) (
  input  wire logic              clk_i,             // 40 MHz clock
  input  wire logic              reset_i,           // Sync reset
  input  wire logic              clk_en_i,          // Freezes state
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,    // Write address
  input  wire logic              s_axi_awvalid_i,   // Write addr valid
  output logic                   s_axi_awready_o,   // Write addr ready
  input  wire logic [31:0]       s_axi_wdata_i,     // Write data
  input  wire logic [3:0]        s_axi_wstrb_i,     // Byte strobes
  input  wire logic              s_axi_wvalid_i,    // Write data valid
  output logic                   s_axi_wready_o,    // Write data ready
  output logic [1:0]             s_axi_bresp_o,     // Write response
  output logic                   s_axi_bvalid_o,    // Response valid
  input  wire logic              s_axi_bready_i,    // Response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,    // Read address
  input  wire logic              s_axi_arvalid_i,   // Read addr valid
  output logic                   s_axi_arready_o,   // Read addr ready
  output logic [31:0]            s_axi_rdata_o,     // Read data
  output logic [1:0]             s_axi_rresp_o,     // Read response
  output logic                   s_axi_rvalid_o,    // Read data valid
  input  wire logic              s_axi_rready_i,    // Read data ready
  input  wire logic              sleep_exec_i,      // Sleep instruction
  input  wire logic [3:0]        wave_set_i,        // Waveform events
  input  wire logic              periph_wake_i,     // Enabled sleep irq
  input  wire logic              wdt_timeout_i,     // Watchdog expiry
  input  wire logic              ext_int_pin_i,     // External int pin
  input  wire logic              ext_reset_pin_i,   // Reset pin
  input  wire logic              brown_out_i,       // Brown-out detect
  input  wire logic              power_on_i,        // Power-on detect
  output logic                   core_clk_en_o,     // Core clock gate
  output logic                   prefetch_o,        // Fetch PC + 1
  output logic                   sleep_nop_o,       // Sleep as no-op
  output logic                   wdt_clear_o,       // Clear watchdog
  output logic                   wdt_run_o,         // Watchdog may count
  output logic                   lfosc_run_o,       // Low-freq osc on
  output logic                   tmr1_run_o,        // Timer one clocked
  output logic                   adc_run_o,         // Converter clocked
  output logic                   io_hold_o,         // Freeze I/O ports
  output logic                   reg_lowpower_o,    // Regulator low-power
  output logic                   full_reset_o,      // Device reset
  output logic                   resume_o,          // Continue program
  output logic                   isr_call_o,        // Call service
  output logic [15:0]            isr_vector_o,      // Service address
  output logic                   power_down_status_o, // Power-down bit
  output logic                   time_out_status_o  // Time-out bit
);
  if (ADDR_W < 8 || DLY_W < $clog2(swc_pkg::OST_CYC + swc_pkg::REG_STAB_CYC + 1))
  begin : g_bad_param
    $error("swc_sleep_ctrl: ADDR_W or DLY_W too small");
  end

  // Pin synchronisers
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else if (clk_en_i) begin
      sync1_r <= {power_on_i, brown_out_i, ext_reset_pin_i, ext_int_pin_i};
      sync2_r <= sync1_r;
    end
  end
  logic ext_int_s, pin_rst_s, bor_s, por_s;
  assign {por_s, bor_s, pin_rst_s, ext_int_s} = sync2_r;

  // Bus and register state
  logic                       aw_rdy_r, aw_rdy_nxt, ar_rdy_r, ar_rdy_nxt;
  logic                       bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]                 bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]                rdata_r, rdata_nxt;
  logic [7:0]                 intctl_r, intctl_nxt;
  logic [swc_pkg::FLAG_N-1:0] peripheral_enable_six_r, peripheral_enable_six_nxt, peripheral_request_flags_six_r, peripheral_request_flags_six_nxt;
  logic [swc_pkg::CFG_W-1:0]  cfg_r, cfg_nxt;
  logic                       wr_fire, rd_fire, asleep;
  logic                       pd_r, to_r;
  swc_pkg::swc_state_e        st_r, st_nxt;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  assign wr_fire = aw_rdy_r && s_axi_awvalid_i && s_axi_wvalid_i;
  assign rd_fire = ar_rdy_r && s_axi_arvalid_i;
  assign asleep  = (st_r != swc_pkg::SWC_RUN) && (st_r != swc_pkg::SWC_RESUME);

  always_comb begin
    logic wmap, rmap, wl0;
    wmap = hit(s_axi_awaddr_i, swc_pkg::OFS_INTCTL) || hit(s_axi_awaddr_i, swc_pkg::OFS_PERIPHERAL_ENABLE_SIX)
        || hit(s_axi_awaddr_i, swc_pkg::OFS_PERIPHERAL_REQUEST_FLAGS_SIX) || hit(s_axi_awaddr_i, swc_pkg::OFS_CFG)
        || hit(s_axi_awaddr_i, swc_pkg::OFS_STAT);
    rmap = 1'b1;
    wl0  = wr_fire && s_axi_wstrb_i[0];
    // Address and data are taken together, one transfer at a time
    aw_rdy_nxt = !aw_rdy_r && !bvalid_r && s_axi_awvalid_i && s_axi_wvalid_i;
    ar_rdy_nxt = !ar_rdy_r && !rvalid_r && s_axi_arvalid_i;
    bvalid_nxt = wr_fire || (bvalid_r && !s_axi_bready_i);
    bresp_nxt  = wr_fire ? (wmap ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR) : bresp_r;
    rvalid_nxt = rd_fire || (rvalid_r && !s_axi_rready_i);
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rd_fire) begin
      rdata_nxt = 32'h0;
      if (hit(s_axi_araddr_i, swc_pkg::OFS_INTCTL)) begin
        rdata_nxt[7:0] = intctl_r;
      end else if (hit(s_axi_araddr_i, swc_pkg::OFS_PERIPHERAL_ENABLE_SIX)) begin
        rdata_nxt[swc_pkg::FLAG_N-1:0] = peripheral_enable_six_r;
      end else if (hit(s_axi_araddr_i, swc_pkg::OFS_PERIPHERAL_REQUEST_FLAGS_SIX)) begin
        rdata_nxt[swc_pkg::FLAG_N-1:0] = peripheral_request_flags_six_r;
      end else if (hit(s_axi_araddr_i, swc_pkg::OFS_CFG)) begin
        rdata_nxt[swc_pkg::CFG_W-1:0] = cfg_r;
      end else if (hit(s_axi_araddr_i, swc_pkg::OFS_STAT)) begin
        rdata_nxt[swc_pkg::STAT_PD]     = pd_r;
        rdata_nxt[swc_pkg::STAT_TO]     = to_r;
        rdata_nxt[swc_pkg::STAT_ASLEEP] = asleep;
      end else begin
        rmap = 1'b0;
      end
      rresp_nxt = rmap ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
    end
    intctl_nxt = (wl0 && hit(s_axi_awaddr_i, swc_pkg::OFS_INTCTL))
               ? s_axi_wdata_i[7:0] : intctl_r;
    peripheral_enable_six_nxt   = (wl0 && hit(s_axi_awaddr_i, swc_pkg::OFS_PERIPHERAL_ENABLE_SIX))
               ? s_axi_wdata_i[swc_pkg::FLAG_N-1:0] : peripheral_enable_six_r;
    cfg_nxt    = (wr_fire && s_axi_wstrb_i[1:0] == 2'h3 && hit(s_axi_awaddr_i, swc_pkg::OFS_CFG))
               ? s_axi_wdata_i[swc_pkg::CFG_W-1:0] : cfg_r;
    // A flag event in the cycle of a software clear still lands
    peripheral_request_flags_six_nxt   = ((wl0 && hit(s_axi_awaddr_i, swc_pkg::OFS_PERIPHERAL_REQUEST_FLAGS_SIX))
               ? s_axi_wdata_i[swc_pkg::FLAG_N-1:0] : peripheral_request_flags_six_r) | wave_set_i;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_rdy_r <= 1'b0;
      ar_rdy_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      bresp_r  <= swc_pkg::RESP_OKAY;
      rresp_r  <= swc_pkg::RESP_OKAY;
      rdata_r  <= 32'h0;
      intctl_r <= swc_pkg::RST_INTCTL;
      peripheral_enable_six_r   <= swc_pkg::RST_PERIPHERAL_ENABLE_SIX;
      peripheral_request_flags_six_r   <= swc_pkg::RST_PERIPHERAL_REQUEST_FLAGS_SIX;
      cfg_r    <= swc_pkg::RST_CFG;
    end else if (clk_en_i) begin
      aw_rdy_r <= aw_rdy_nxt;
      ar_rdy_r <= ar_rdy_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
      bresp_r  <= bresp_nxt;
      rresp_r  <= rresp_nxt;
      rdata_r  <= rdata_nxt;
      intctl_r <= intctl_nxt;
      peripheral_enable_six_r   <= peripheral_enable_six_nxt;
      peripheral_request_flags_six_r   <= peripheral_request_flags_six_nxt;
      cfg_r    <= cfg_nxt;
    end
  end

  assign s_axi_awready_o = aw_rdy_r;
  assign s_axi_wready_o  = aw_rdy_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = ar_rdy_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rresp_o   = rresp_r;
  assign s_axi_rdata_o   = rdata_r;

  // Sequencer
  logic global_interrupt_enable, pend, wake_ev, rst_src, dly_zero, dly_load;
  logic [DLY_W-1:0] dly_val;
  logic pd_nxt, to_nxt, irq_wake_r, irq_wake_nxt;
  logic clk_on_r, clk_on_nxt, pf_r, pf_nxt, nop_r, nop_nxt, wclr_r, wclr_nxt;
  logic wrun_r, wrun_nxt, t1_r, t1_nxt, adc_r, adc_nxt, hold_r, hold_nxt;
  logic lp_r, lp_nxt, frst_r, frst_nxt, res_r, res_nxt, isr_r, isr_nxt;

  assign global_interrupt_enable  = intctl_r[swc_pkg::INTCTL_GIE];
  // Global enable plays no part in waking
  assign pend = |(peripheral_request_flags_six_r & peripheral_enable_six_r) || (ext_int_s && intctl_r[swc_pkg::INTCTL_EXT_IE])
             || periph_wake_i;
  assign wake_ev = pend || (wdt_timeout_i && cfg_r[swc_pkg::CFG_WDT_EN]);
  assign rst_src = (pin_rst_s && cfg_r[swc_pkg::CFG_PIN_EN])
                || (bor_s && cfg_r[swc_pkg::CFG_BOR_EN]) || por_s;
  // Oscillator wait only for crystal modes without two-speed start, plus regulator settling when low-power is selected
  assign dly_val = ((cfg_r[swc_pkg::CFG_XTAL] && !cfg_r[swc_pkg::CFG_TWOSPD])
                    ? DLY_W'(swc_pkg::OST_CYC) : DLY_W'(0))
                 + (cfg_r[swc_pkg::CFG_REGULATOR_POWER_MODE_SELECT] ? DLY_W'(swc_pkg::REG_STAB_CYC) : DLY_W'(0));

  always_comb begin
    st_nxt = st_r;
    pd_nxt = pd_r;
    to_nxt = to_r;
    irq_wake_nxt = irq_wake_r;
    pf_nxt = 1'b0;
    nop_nxt = 1'b0;
    wclr_nxt = 1'b0;
    frst_nxt = 1'b0;
    res_nxt = 1'b0;
    isr_nxt = 1'b0;
    dly_load = 1'b0;
    case (st_r)
      swc_pkg::SWC_RUN, swc_pkg::SWC_RESUME: begin
        if (wdt_timeout_i && cfg_r[swc_pkg::CFG_WDT_EN]) begin
          frst_nxt = 1'b1;
        end else if (sleep_exec_i) begin
          if (pend && !global_interrupt_enable) begin
            nop_nxt = 1'b1;
          end else begin
            st_nxt   = swc_pkg::SWC_ENTRY;
            pd_nxt   = 1'b0;
            to_nxt   = 1'b1;
            wclr_nxt = 1'b1;
            pf_nxt   = 1'b1;
          end
        end else begin
          st_nxt = swc_pkg::SWC_RUN;
        end
      end
      swc_pkg::SWC_ENTRY, swc_pkg::SWC_SLEEP: begin
        // A wake event during entry lets entry finish, then leaves at once
        if (wake_ev) begin
          st_nxt       = swc_pkg::SWC_WAKE;
          wclr_nxt     = 1'b1;
          dly_load     = 1'b1;
          irq_wake_nxt = pend;
        end else begin
          st_nxt = swc_pkg::SWC_SLEEP;
        end
      end
      swc_pkg::SWC_WAKE: begin
        if (dly_zero) begin
          st_nxt  = swc_pkg::SWC_RESUME;
          res_nxt = 1'b1;
          isr_nxt = irq_wake_r && global_interrupt_enable;
        end
      end
      default: begin
        st_nxt = swc_pkg::SWC_RUN;
      end
    endcase
    if (rst_src) begin
      st_nxt   = swc_pkg::SWC_RUN;
      pd_nxt   = swc_pkg::RST_PD;
      to_nxt   = swc_pkg::RST_TO;
      frst_nxt = 1'b1;
      res_nxt  = 1'b0;
      isr_nxt  = 1'b0;
      dly_load = 1'b0;
    end
    clk_on_nxt = (st_nxt == swc_pkg::SWC_RUN) || (st_nxt == swc_pkg::SWC_RESUME);
    hold_nxt   = !clk_on_nxt;
    wrun_nxt   = clk_on_nxt || cfg_r[swc_pkg::CFG_WDT_SLP];
    t1_nxt     = clk_on_nxt || (cfg_r[swc_pkg::CFG_T1SRC +: 2] != 2'h0);
    adc_nxt    = clk_on_nxt || cfg_r[swc_pkg::CFG_ADC_DED];
    lp_nxt     = (st_nxt == swc_pkg::SWC_SLEEP) && cfg_r[swc_pkg::CFG_REGULATOR_POWER_MODE_SELECT];
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r       <= swc_pkg::SWC_RUN;
      pd_r       <= swc_pkg::RST_PD;
      to_r       <= swc_pkg::RST_TO;
      irq_wake_r <= 1'b0;
      clk_on_r   <= 1'b1;
      pf_r       <= 1'b0;
      nop_r      <= 1'b0;
      wclr_r     <= 1'b0;
      wrun_r     <= 1'b1;
      t1_r       <= 1'b1;
      adc_r      <= 1'b1;
      hold_r     <= 1'b0;
      lp_r       <= 1'b0;
      frst_r     <= 1'b0;
      res_r      <= 1'b0;
      isr_r      <= 1'b0;
    end else if (clk_en_i) begin
      st_r       <= st_nxt;
      pd_r       <= pd_nxt;
      to_r       <= to_nxt;
      irq_wake_r <= irq_wake_nxt;
      clk_on_r   <= clk_on_nxt;
      pf_r       <= pf_nxt;
      nop_r      <= nop_nxt;
      wclr_r     <= wclr_nxt;
      wrun_r     <= wrun_nxt;
      t1_r       <= t1_nxt;
      adc_r      <= adc_nxt;
      hold_r     <= hold_nxt;
      lp_r       <= lp_nxt;
      frst_r     <= frst_nxt;
      res_r      <= res_nxt;
      isr_r      <= isr_nxt;
    end
  end

  swc_delay_timer #(.W(DLY_W)) u_dly (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .clk_en_i (clk_en_i),
    .load_i   (dly_load),
    .value_i  (dly_val),
    .zero_o   (dly_zero)
  );

  assign core_clk_en_o       = clk_on_r;
  assign prefetch_o          = pf_r;
  assign sleep_nop_o         = nop_r;
  assign wdt_clear_o         = wclr_r;
  assign wdt_run_o           = wrun_r;
  assign lfosc_run_o         = 1'b1;
  assign tmr1_run_o          = t1_r;
  assign adc_run_o           = adc_r;
  assign io_hold_o           = hold_r;
  assign reg_lowpower_o      = lp_r;
  assign full_reset_o        = frst_r;
  assign resume_o            = res_r;
  assign isr_call_o          = isr_r;
  assign isr_vector_o        = swc_pkg::ISR_VECTOR;
  assign power_down_status_o = pd_r;
  assign time_out_status_o   = to_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sleep_only_a: assert property ((st_r == swc_pkg::SWC_RUN) && clk_en_i && !sleep_exec_i
    && !rst_src |=> st_r != swc_pkg::SWC_ENTRY) else $error("sleep entered without instruction");
  entry_effects_a: assert property ((st_r == swc_pkg::SWC_RUN) && clk_en_i && sleep_exec_i
    && !(pend && !global_interrupt_enable) && !rst_src && !(wdt_timeout_i && cfg_r[swc_pkg::CFG_WDT_EN])
    |=> wdt_clear_o && prefetch_o && !pd_r && to_r) else $error("sleep entry effects missing");
  clock_gate_a: assert property (asleep |-> !core_clk_en_o && io_hold_o)
    else $error("core clock or ports not frozen in sleep");
  nop_sleep_a: assert property ((st_r == swc_pkg::SWC_RUN) && clk_en_i && sleep_exec_i
    && pend && !global_interrupt_enable && !rst_src && !(wdt_timeout_i && cfg_r[swc_pkg::CFG_WDT_EN])
    |=> sleep_nop_o && !wdt_clear_o && $stable(pd_r) && $stable(to_r))
    else $error("no-op sleep changed state");
  wake_exit_a: assert property ((st_r == swc_pkg::SWC_SLEEP) && clk_en_i && wake_ev && !rst_src
    |=> st_r == swc_pkg::SWC_WAKE && wdt_clear_o) else $error("wake without watchdog clear");
  full_reset_a: assert property (clk_en_i && rst_src
    |=> full_reset_o && core_clk_en_o && pd_r && to_r) else $error("reset source not honoured");
  delay_hold_a: assert property ((st_r == swc_pkg::SWC_WAKE) && !dly_zero
    |-> !core_clk_en_o && !resume_o) else $error("core restarted before delay");
  isr_gate_a: assert property (isr_call_o |-> resume_o && global_interrupt_enable && isr_vector_o == 16'h0004)
    else $error("service call without resume or enable");
  lowpower_a: assert property (reg_lowpower_o |-> st_r == swc_pkg::SWC_SLEEP)
    else $error("regulator low-power outside sleep");
  flag_set_a: assert property (clk_en_i && wave_set_i[0] |=> peripheral_request_flags_six_r[0])
    else $error("waveform flag event lost");

  sleep_wake_c: cover property (st_r == swc_pkg::SWC_SLEEP ##1 st_r == swc_pkg::SWC_WAKE);
  nop_sleep_c: cover property (sleep_nop_o);
  isr_wake_c: cover property (isr_call_o);
  reset_wake_c: cover property (asleep && full_reset_o);
endmodule // swc_sleep_ctrl

// File: test/swc_core_model.sv
// Purpose: Processor core model facing the sleep controller
// Assumes: One sleep instruction per request
// Notes:   A service call loads the vector in place of the prefetched word
`timescale 1ns/1ps
module swc_core_model (
  input  wire logic        clk_i,      // System clock
  input  wire logic        reset_i,    // Sync reset
  input  wire logic        go_i,       // Bench asks for a sleep
  input  wire logic        prefetch_i, // Fetch next word
  input  wire logic        resume_i,   // Wake continues program
  input  wire logic        isr_i,      // Service call on resume
  input  wire logic [15:0] vector_i,   // Service address
  output logic             sleep_o,    // Sleep instruction
  output logic [15:0]      pc_o        // Program counter
);
  logic [15:0] fetch_r;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sleep_o <= 1'b0;
      pc_o    <= 16'h0100;
      fetch_r <= 16'h0000;
    end else begin
      sleep_o <= go_i;
      if (prefetch_i) fetch_r <= pc_o + 16'h0001;
      if (resume_i) pc_o <= isr_i ? vector_i : fetch_r;
    end
  end
endmodule // swc_core_model

// File: test/tb.sv
// Purpose: Self-checking bench for the sleep and wake controller
// Assumes: Core model issues sleeps, bench owns bus and wake inputs
// Notes:   Register model held in an associative array
`timescale 1ns/1ps
module tb;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdata, seed = 32'h000067bf, mdl[int];
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [3:0]  wave = 4'h0;
  logic        go = 1'b0, pw = 1'b0, wto = 1'b0, por = 1'b0, sx, pf, res, isr, ce;
  logic        awr, wrdy, bv, arr, rv, nop, clr, lowp, hold, full, pd, to, t1, adc, lf, wr;
  logic [1:0]  bresp, rresp;
  logic [15:0] vec, pc, pc0;
  int          n_errors = 0, checks = 0, n;
  logic [31:0] cfgs[5] = '{32'h380, 32'h394, 32'h3ac, 32'h3b1, 32'h3c5};
  int          dly[5] = '{0, 1024, 0, swc_pkg::REG_STAB_CYC, 1024 + swc_pkg::REG_STAB_CYC};
  always #12.5 clk_i = ~clk_i;
  swc_sleep_ctrl uut (
    .clk_i(clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .sleep_exec_i(sx), .wave_set_i(wave), .periph_wake_i(pw), .wdt_timeout_i(wto),
    .ext_int_pin_i(1'b0), .ext_reset_pin_i(1'b0), .brown_out_i(1'b0), .power_on_i(por),
    .core_clk_en_o(ce), .prefetch_o(pf), .sleep_nop_o(nop), .wdt_clear_o(clr),
    .wdt_run_o(wr), .lfosc_run_o(lf), .tmr1_run_o(t1), .adc_run_o(adc), .io_hold_o(hold),
    .reg_lowpower_o(lowp), .full_reset_o(full), .resume_o(res), .isr_call_o(isr),
    .isr_vector_o(vec), .power_down_status_o(pd), .time_out_status_o(to));
  swc_core_model core (
    .clk_i(clk_i), .reset_i(reset_i), .go_i(go), .prefetch_i(pf), .resume_i(res),
    .isr_i(isr), .vector_i(vec), .sleep_o(sx), .pc_o(pc));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bound(input int i);
    if (i >= 2000) begin
      n_errors++;
      give_verdict();
    end
  endtask
  // One transfer; write when w, data compared only on reads
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    int i;
    @(posedge clk_i);
    awa <= a;
    ara <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    arv <= !w;
    br <= w;
    rr <= !w;
    for (i = 0; i < 2000 && !(w ? awr : arr); i++) @(posedge clk_i);
    awv <= 1'b0;
    wv <= 1'b0;
    arv <= 1'b0;
    for (; i < 2000 && !(w ? bv : rv); i++) @(posedge clk_i);
    br <= 1'b0;
    rr <= 1'b0;
    bound(i);
    chk(w ? bresp : rresp, r);
    if (!w) chk(rdata, d);
  endtask
  // Leaves 1 ns after the edge that shows the controller's answer
  task automatic sleep_in(input logic nop_exp);
    @(posedge clk_i);
    go <= 1'b1;
    pc0 = pc;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    #1;
    chk({nop, ce, hold, clr, pf}, nop_exp ? 5'b11000 : 5'b00111);
    if (!nop_exp) chk({pd, to}, 2'b01);
  endtask
  task automatic wake_wait(input logic isr_exp, input logic [15:0] pc_exp);
    int c;
    c = 0;
    for (n = 0; n < 2000 && !res; n++) begin
      @(posedge clk_i);
      wave <= 4'h0;
      // Watchdog expiry is a one-edge pulse, dropped here like the flag events
      wto <= 1'b0;
      if (n > 0) c += clr;
    end
    pw <= 1'b0;
    bound(n);
    chk({isr, ce, c > 0}, {isr_exp, 2'b11});
    #1;
    chk(pc, pc_exp);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    mdl[0] = 32'h0;
    mdl[4] = 32'h0;
    mdl[8] = 32'h0;
    mdl[12] = 32'h380;
    mdl[16] = 32'h3;
    foreach (mdl[a]) bus(1'b0, 8'(a), mdl[a], 2'h0);
    bus(1'b0, 8'h20, 32'h0, 2'h2);
    seed = xs(seed);
    wave <= seed[3:0];
    @(posedge clk_i);
    wave <= 4'h0;
    bus(1'b0, 8'h08, {28'h0, seed[3:0]}, 2'h0);
    bus(1'b1, 8'h08, 32'hffffffff, 2'h0);
    bus(1'b0, 8'h08, 32'hf, 2'h0);
    bus(1'b1, 8'h08, 32'h0, 2'h0);
    bus(1'b1, 8'h04, 32'h1, 2'h0);
    sleep_in(1'b0);
    bus(1'b0, 8'h10, 32'h6, 2'h0);
    // A flag whose enable is clear must not wake the core
    wave <= 4'h2;
    @(posedge clk_i);
    wave <= 4'h0;
    bus(1'b0, 8'h08, 32'h2, 2'h0);
    chk(ce, 1'b0);
    wave <= 4'h1;
    wake_wait(1'b0, pc0 + 16'h0001);
    bus(1'b0, 8'h10, 32'h2, 2'h0);
    sleep_in(1'b1);
    bus(1'b0, 8'h10, 32'h2, 2'h0);
    bus(1'b1, 8'h00, 32'h80, 2'h0);
    sleep_in(1'b0);
    wake_wait(1'b1, 16'h0004);
    bus(1'b1, 8'h08, 32'h0, 2'h0);
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 8'h0c, cfgs[k], 2'h0);
      sleep_in(1'b0);
      @(posedge clk_i);
      pw <= 1'b1;
      #1;
      chk({lowp, t1, adc, lf, wr}, {cfgs[k][0], |cfgs[k][5:4], cfgs[k][6], 1'b1, cfgs[k][1]});
      wake_wait(1'b1, 16'h0004);
      chk(n >= dly[k] + 1 && n <= dly[k] + 5, 1'b1);
    end
    bus(1'b1, 8'h0c, 32'h382, 2'h0);
    sleep_in(1'b0);
    @(posedge clk_i);
    wto <= 1'b1;
    chk(wr, 1'b1);
    wake_wait(1'b0, pc0 + 16'h0001);
    sleep_in(1'b0);
    @(posedge clk_i);
    por <= 1'b1;
    for (n = 0; n < 8 && !full; n++) @(posedge clk_i);
    por <= 1'b0;
    // Two-flop synchroniser still carries the pulse
    repeat (3) @(posedge clk_i);
    chk({n < 8, ce, pd, to}, 4'hf);
    give_verdict();
  end
endmodule // tb
